// [timer_channel_status_flags.sv]
// Notes on behaviour
// R1 - Counter overflow sets bit 0 until read
// R2 - Capture double load sets bit 1
// R3 - Wave mode compare A sets bit 2
// R4 - Wave mode compare B sets bit 3
// R5 - Compare C sets bit 4 any mode
// R6 - Capture mode load A sets bit 5
// R7 - Capture mode load B sets bit 6
// R8 - External trigger sets bit 7 any mode
// R9 - Status read clears; concurrent event survives
`timescale 1ns/1ps
`include "timer_channel_consts.svh"

module timer_channel_status_flags #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic clock, // 40 MHz channel clock
  input wire logic rst_n, // Async reset, low
  input wire logic [ADDR_W-1:0] addr, // Register byte address
  input wire logic [DATA_W-1:0] wrData, // Write data
  input wire logic wrStrobe, // Write strobe
  input wire logic rdStrobe, // Read strobe
  input timer_channel_pkg::chanEvents_s events, // Event pulses
  output logic [DATA_W-1:0] rdData, // Read data, next cycle
  output logic waveMode, // Current mode, high = wave
  output logic irq // Level interrupt
);

  // ========================================================================
  // Parameter checks
  if (ADDR_W < 6 || ADDR_W > 8) begin : gAddrWCheck
    $error("ADDR_W must be 6 to 8");
  end
  if (DATA_W != 32) begin : gDataWCheck
    $error("DATA_W must be 32");
  end
  if (`FLAG_COUNT != $bits(timer_channel_pkg::flagVec_t)) begin : gFlagCheck
    $error("Flag count does not match the flag vector");
  end
  if (`FLAG_COUNT > DATA_W) begin : gFlagFitCheck
    $error("Flags do not fit the data word");
  end
  if (`MODE_WAVE_BIT >= DATA_W) begin : gModeBitCheck
    $error("Mode bit outside the data word");
  end

  // ========================================================================
  // Helpers
  function automatic logic hitAddr(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
    hitAddr = (a == ofs[ADDR_W-1:0]);
  endfunction : hitAddr

  function automatic timer_channel_pkg::flagVec_t qualify(
      input timer_channel_pkg::flagVec_t raw,
      input timer_channel_pkg::chanMode_e mode);
    timer_channel_pkg::flagVec_t keep;
    keep = 8'hFF;
    unique case (mode)
      timer_channel_pkg::MODE_WAVE: keep = ~`CAPTURE_ONLY_FLAGS;
      timer_channel_pkg::MODE_CAPTURE: keep = ~`WAVE_ONLY_FLAGS;
    endcase
    qualify = raw & keep;
  endfunction : qualify

  function automatic logic [DATA_W-1:0] wordOf(
      input timer_channel_pkg::flagVec_t v);
    wordOf = {{(DATA_W-`FLAG_COUNT){1'b0}}, v};
  endfunction : wordOf

  // ========================================================================
  // Bus decode
  logic wrMode;
  logic wrIrqPend;
  logic wrIrqMask;
  logic rdStatus;
  logic rdMode;
  logic rdIrqPend;
  logic rdIrqMask;

  assign wrMode = wrStrobe & hitAddr(addr, `CH_MODE_OFS);
  assign wrIrqPend = wrStrobe & hitAddr(addr, `CH_IRQ_PEND_OFS);
  assign wrIrqMask = wrStrobe & hitAddr(addr, `CH_IRQ_MASK_OFS);
  assign rdStatus = rdStrobe & hitAddr(addr, `CH_EVENT_STATUS_OFS);
  assign rdMode = rdStrobe & hitAddr(addr, `CH_MODE_OFS);
  assign rdIrqPend = rdStrobe & hitAddr(addr, `CH_IRQ_PEND_OFS);
  assign rdIrqMask = rdStrobe & hitAddr(addr, `CH_IRQ_MASK_OFS);

  // ========================================================================
  // Mode register
  timer_channel_pkg::chanMode_e mode_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= timer_channel_pkg::MODE_CAPTURE;
    end else if (wrMode) begin
      mode_ff <= wrData[`MODE_WAVE_BIT] ? timer_channel_pkg::MODE_WAVE
                                        : timer_channel_pkg::MODE_CAPTURE;
    end
  end

  logic isWave;
  logic isCapture;

  assign isWave = (mode_ff == timer_channel_pkg::MODE_WAVE);
  assign isCapture = (mode_ff == timer_channel_pkg::MODE_CAPTURE);

  // ========================================================================
  // Load overrun detection per capture register
  logic overrunA;
  logic overrunB;

  capture_overrun_tracker trackA (
    .clock(clock),
    .rst_n(rst_n),
    .captureMode(isCapture),
    .loadEv(events.loadA),
    .readEv(events.capARead),
    .overrunEv(overrunA)
  );

  capture_overrun_tracker trackB (
    .clock(clock),
    .rst_n(rst_n),
    .captureMode(isCapture),
    .loadEv(events.loadB),
    .readEv(events.capBRead),
    .overrunEv(overrunB)
  );

  // ========================================================================
  // Event set vector, already qualified by mode
  timer_channel_pkg::flagVec_t setVec;

  always_comb begin
    setVec = `FLAGS_RESET;
    setVec[`FLAG_COUNTER_WRAP] = events.counterWrap; // [R1]
    setVec[`FLAG_LOAD_OVERRUN] = isCapture & (overrunA | overrunB); // [R2]
    setVec[`FLAG_CMP_A] = isWave & events.cmpA; // [R3]
    setVec[`FLAG_CMP_B] = isWave & events.cmpB; // [R4]
    setVec[`FLAG_CMP_C] = events.cmpC; // [R5]
    setVec[`FLAG_LOAD_A] = isCapture & events.loadA; // [R6]
    setVec[`FLAG_LOAD_B] = isCapture & events.loadB; // [R7]
    setVec[`FLAG_EXT_TRIGGER] = events.extTrigger; // [R8]
  end

  // ========================================================================
  // Sticky status flags, cleared by a status read
  logic counterWrapFlag_ff;
  logic loadOverrunFlag_ff;
  logic cmpAFlag_ff;
  logic cmpBFlag_ff;
  logic cmpCFlag_ff;
  logic loadAFlag_ff;
  logic loadBFlag_ff;
  logic extTriggerFlag_ff;

  // Set wins over a clear by the same status read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      counterWrapFlag_ff <= 1'b0;
    end else if (setVec[`FLAG_COUNTER_WRAP]) begin
      counterWrapFlag_ff <= 1'b1; // [R1] [R9]
    end else if (rdStatus) begin
      counterWrapFlag_ff <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loadOverrunFlag_ff <= 1'b0;
    end else if (setVec[`FLAG_LOAD_OVERRUN]) begin
      loadOverrunFlag_ff <= 1'b1; // [R2] [R9]
    end else if (rdStatus) begin
      loadOverrunFlag_ff <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmpAFlag_ff <= 1'b0;
    end else if (setVec[`FLAG_CMP_A]) begin
      cmpAFlag_ff <= 1'b1; // [R3] [R9]
    end else if (rdStatus) begin
      cmpAFlag_ff <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmpBFlag_ff <= 1'b0;
    end else if (setVec[`FLAG_CMP_B]) begin
      cmpBFlag_ff <= 1'b1; // [R4] [R9]
    end else if (rdStatus) begin
      cmpBFlag_ff <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmpCFlag_ff <= 1'b0;
    end else if (setVec[`FLAG_CMP_C]) begin
      cmpCFlag_ff <= 1'b1; // [R5] [R9]
    end else if (rdStatus) begin
      cmpCFlag_ff <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loadAFlag_ff <= 1'b0;
    end else if (setVec[`FLAG_LOAD_A]) begin
      loadAFlag_ff <= 1'b1; // [R6] [R9]
    end else if (rdStatus) begin
      loadAFlag_ff <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loadBFlag_ff <= 1'b0;
    end else if (setVec[`FLAG_LOAD_B]) begin
      loadBFlag_ff <= 1'b1; // [R7] [R9]
    end else if (rdStatus) begin
      loadBFlag_ff <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extTriggerFlag_ff <= 1'b0;
    end else if (setVec[`FLAG_EXT_TRIGGER]) begin
      extTriggerFlag_ff <= 1'b1; // [R8] [R9]
    end else if (rdStatus) begin
      extTriggerFlag_ff <= 1'b0; // [R9]
    end
  end

  // ========================================================================
  // Status image, flags of the other mode read as zero
  timer_channel_pkg::flagVec_t rawFlags;
  timer_channel_pkg::flagVec_t statusImage;

  always_comb begin
    rawFlags = `FLAGS_RESET;
    rawFlags[`FLAG_COUNTER_WRAP] = counterWrapFlag_ff;
    rawFlags[`FLAG_LOAD_OVERRUN] = loadOverrunFlag_ff;
    rawFlags[`FLAG_CMP_A] = cmpAFlag_ff;
    rawFlags[`FLAG_CMP_B] = cmpBFlag_ff;
    rawFlags[`FLAG_CMP_C] = cmpCFlag_ff;
    rawFlags[`FLAG_LOAD_A] = loadAFlag_ff;
    rawFlags[`FLAG_LOAD_B] = loadBFlag_ff;
    rawFlags[`FLAG_EXT_TRIGGER] = extTriggerFlag_ff;
  end

  assign statusImage = qualify(rawFlags, mode_ff); // [R2] [R3] [R4] [R6] [R7]

  // ========================================================================
  // Interrupt pending and mask, write one to clear pending
  timer_channel_pkg::flagVec_t irqPend_ff;
  timer_channel_pkg::flagVec_t irqMask_ff;
  timer_channel_pkg::flagVec_t nxt_irqPend;
  timer_channel_pkg::flagVec_t clrPend;

  assign clrPend = wrIrqPend ? wrData[`FLAG_COUNT-1:0] : `FLAGS_RESET;

  // Set wins over a clear in the same cycle
  assign nxt_irqPend = (irqPend_ff & ~clrPend) | setVec;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqPend_ff <= `FLAGS_RESET;
    end else begin
      irqPend_ff <= nxt_irqPend;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqMask_ff <= `MASK_RESET;
    end else if (wrIrqMask) begin
      irqMask_ff <= wrData[`FLAG_COUNT-1:0];
    end
  end

  logic irq_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_irqPend & irqMask_ff);
    end
  end

  // ========================================================================
  // Read mux, registered one cycle after the strobe
  logic [DATA_W-1:0] rdData_ff;
  logic [DATA_W-1:0] nxt_rdData;

  // Unmapped addresses and idle cycles read zero
  always_comb begin
    nxt_rdData = '0;
    if (rdStatus) begin
      nxt_rdData = wordOf(statusImage); // [R9]
    end else if (rdMode) begin
      nxt_rdData[`MODE_WAVE_BIT] = isWave;
    end else if (rdIrqPend) begin
      nxt_rdData = wordOf(irqPend_ff);
    end else if (rdIrqMask) begin
      nxt_rdData = wordOf(irqMask_ff);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // ========================================================================
  // Mode output
  logic waveMode_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waveMode_ff <= `MODE_RESET;
    end else if (wrMode) begin
      waveMode_ff <= wrData[`MODE_WAVE_BIT];
    end
  end

  // ========================================================================
  // Outputs
  assign rdData = rdData_ff;
  assign waveMode = waveMode_ff;
  assign irq = irq_ff;

endmodule : timer_channel_status_flags

// [timer_channel_consts.svh]
`ifndef TIMER_CHANNEL_CONSTS_SVH
`define TIMER_CHANNEL_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define CH_MODE_OFS 8'h04
`define CH_EVENT_STATUS_OFS 8'h20
`define CH_IRQ_PEND_OFS 8'h24
`define CH_IRQ_MASK_OFS 8'h28

// ==========================================================================
// Event flag bit positions
`define FLAG_COUNTER_WRAP 0
`define FLAG_LOAD_OVERRUN 1
`define FLAG_CMP_A 2
`define FLAG_CMP_B 3
`define FLAG_CMP_C 4
`define FLAG_LOAD_A 5
`define FLAG_LOAD_B 6
`define FLAG_EXT_TRIGGER 7
`define FLAG_COUNT 8

// ==========================================================================
// Mode register field and reset values
`define MODE_WAVE_BIT 0
`define MODE_RESET 1'h0
`define FLAGS_RESET 8'h00
`define MASK_RESET 8'h00

// ==========================================================================
// Flags that only exist in one of the two modes
`define CAPTURE_ONLY_FLAGS 8'h62
`define WAVE_ONLY_FLAGS 8'h0C

`endif

// [timer_channel_pkg.sv]
package timer_channel_pkg;

  // ========================================================================
  // Channel operating mode
  typedef enum logic {
    MODE_CAPTURE,
    MODE_WAVE
  } chanMode_e;

  // ========================================================================
  // One-cycle event pulses from the counter core
  typedef struct packed {
    logic counterWrap;
    logic cmpA;
    logic cmpB;
    logic cmpC;
    logic loadA;
    logic loadB;
    logic extTrigger;
    logic capARead;
    logic capBRead;
  } chanEvents_s;

  typedef logic [7:0] flagVec_t;

endpackage : timer_channel_pkg

// [capture_overrun_tracker.sv]
`timescale 1ns/1ps
`include "timer_channel_consts.svh"

module capture_overrun_tracker (
  input wire logic clock, // Channel clock
  input wire logic rst_n, // Async reset, low
  input wire logic captureMode, // High in capture mode
  input wire logic loadEv, // Capture register loaded
  input wire logic readEv, // Capture register read
  output logic overrunEv // Load over unread value
);

  // ========================================================================
  // Unread value tracking
  logic unread_ff;
  logic nxt_unread;

  always_comb begin
    nxt_unread = unread_ff;
    if (!captureMode) begin
      nxt_unread = 1'b0;
    end else if (loadEv) begin
      nxt_unread = 1'b1;
    end else if (readEv) begin
      nxt_unread = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unread_ff <= 1'b0;
    end else begin
      unread_ff <= nxt_unread;
    end
  end

  // A read in the same cycle consumes the old value first
  assign overrunEv = captureMode & loadEv & unread_ff & ~readEv;

endmodule : capture_overrun_tracker

// [timer_channel_status_flags_asserts.sv]
`timescale 1ns/1ps
`include "timer_channel_consts.svh"

module timer_channel_status_flags_asserts #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset, low
  input wire logic [ADDR_W-1:0] addr, // Address
  input wire logic [DATA_W-1:0] wrData, // Write data
  input wire logic wrStrobe, // Write strobe
  input wire logic rdStrobe, // Read strobe
  input wire timer_channel_pkg::chanEvents_s events, // Events
  input wire logic [DATA_W-1:0] rdData, // Read data
  input wire logic waveMode, // Mode
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic stRd;
  logic mskWr;
  assign stRd = rdStrobe && addr == `CH_EVENT_STATUS_OFS;
  assign mskWr = wrStrobe && addr == `CH_IRQ_MASK_OFS;

  a_idle_read_zero: assert property (!rdStrobe |=> rdData == '0)
    else $error("read data not zero when idle");
  a_wrap_flag_seen: assert property (
    events.counterWrap ##1 stRd |=> rdData[0])
    else $error("wrap flag missing");
  a_wave_hides_load: assert property (
    stRd && waveMode |=> rdData[6:5] == 2'h0 && !rdData[1])
    else $error("capture flags visible in wave mode");
  a_capture_hides_cmp: assert property (
    stRd && !waveMode |=> rdData[3:2] == 2'h0)
    else $error("compare flags visible in capture mode");
  a_cmpc_flag_seen: assert property (
    events.cmpC ##1 stRd |=> rdData[4])
    else $error("compare C flag missing");
  a_trigger_flag_seen: assert property (
    events.extTrigger ##1 stRd |=> rdData[7])
    else $error("trigger flag missing");
  a_read_clears_flags: assert property (
    stRd && events == '0 ##1 stRd |=> rdData[7:0] == 8'h00)
    else $error("flags not cleared by read");
  a_mask_off_irq: assert property (
    mskWr && wrData[7:0] == 8'h00 ##1 !mskWr |=> !irq)
    else $error("irq high with empty mask");
  a_mode_follows_write: assert property (
    wrStrobe && addr == `CH_MODE_OFS |=> waveMode == $past(wrData[0]))
    else $error("mode not updated");

  c_status_nonzero: cover property (stRd ##1 rdData[7:0] != 8'h00);
  c_irq_rise: cover property ($rose(irq));
  c_wave_entry: cover property ($rose(waveMode));
endmodule : timer_channel_status_flags_asserts

bind timer_channel_status_flags timer_channel_status_flags_asserts #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clock(clock), .rst_n(rst_n),
  .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
  .events(events), .rdData(rdData), .waveMode(waveMode), .irq(irq));

// [timer_channel_status_flags_tb.sv]
`timescale 1ns/1ps
`include "timer_channel_consts.svh"

module timer_channel_status_flags_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic wrStrobe = 1'b0;
  logic rdStrobe = 1'b0;
  timer_channel_pkg::chanEvents_s events = '0;
  logic [31:0] rdData;
  logic waveMode;
  logic irq;
  logic rdLast = 1'b0;
  logic [31:0] expQ[$];
  logic [7:0] flg = 8'h00;
  logic [7:0] pend = 8'h00;
  logic [7:0] msk = 8'h00;
  logic mode = 1'b0;
  logic unrA = 1'b0;
  logic unrB = 1'b0;
  logic irqExp = 1'b0;
  logic [7:0] regs[5] = '{8'h04, 8'h20, 8'h24, 8'h28, 8'h30};
  int bad_count = 0;
  int compares = 0;

  always #12.5 clock = ~clock;

  timer_channel_status_flags uut (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .events(events), .rdData(rdData), .waveMode(waveMode), .irq(irq));

  // ====================
  // Compare and monitor
  task automatic check(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  always @(posedge clock) begin
    rdLast <= rdStrobe;
    if (rdLast && expQ.size() > 0) begin
      check(rdData, expQ.pop_front());
    end
  end

  // ====================
  // One bus cycle plus reference model
  task automatic step(logic w, logic r, logic [7:0] a, logic [31:0] d,
                      timer_channel_pkg::chanEvents_s e);
    logic [31:0] rv;
    logic ovr;
    logic [7:0] s;
    wrStrobe <= w;
    rdStrobe <= r;
    addr <= a;
    wrData <= d;
    events <= e;
    @(negedge clock);
    check({31'h0, irq}, {31'h0, irqExp});
    check({31'h0, waveMode}, {31'h0, mode});
    ovr = !mode && ((e.loadA && unrA && !e.capARead) ||
                    (e.loadB && unrB && !e.capBRead));
    s = {e.extTrigger, e.loadB & !mode, e.loadA & !mode, e.cmpC,
         e.cmpB & mode, e.cmpA & mode, ovr, e.counterWrap};
    case (a)
      `CH_EVENT_STATUS_OFS: rv = {24'h0, flg & (mode ? 8'h9D : 8'hF3)};
      `CH_MODE_OFS: rv = {31'h0, mode};
      `CH_IRQ_PEND_OFS: rv = {24'h0, pend};
      `CH_IRQ_MASK_OFS: rv = {24'h0, msk};
      default: rv = 32'h0;
    endcase
    if (r) expQ.push_back(rv);
    unrA = !mode && (e.loadA || (unrA && !e.capARead));
    unrB = !mode && (e.loadB || (unrB && !e.capBRead));
    if (r && a == `CH_EVENT_STATUS_OFS) flg = 8'h00;
    flg |= s;
    if (w && a == `CH_IRQ_PEND_OFS) pend &= ~d[7:0];
    pend |= s;
    irqExp = |(pend & msk);
    if (w && a == `CH_IRQ_MASK_OFS) msk = d[7:0];
    if (w && a == `CH_MODE_OFS) mode = d[0];
    @(posedge clock);
  endtask : step

  task automatic rd(logic [7:0] a);
    step(1'b0, 1'b1, a, 32'h0, '0);
  endtask : rd

  task automatic wr(logic [7:0] a, logic [31:0] d);
    step(1'b1, 1'b0, a, d, '0);
  endtask : wr

  task automatic ev(logic [8:0] e);
    step(1'b0, 1'b0, 8'h00, 32'h0, timer_channel_pkg::chanEvents_s'(e));
  endtask : ev

  task automatic wrap_up;
    for (int k = 0; k < 4 && expQ.size() > 0; k++) @(posedge clock);
    if (expQ.size() > 0) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, expQ[0]);
    end
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // ====================
  // Scenarios
  initial begin
    logic r;
    logic w;
    timer_channel_pkg::chanEvents_s e;
    void'($urandom(46946));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (regs[i]) rd(regs[i]);
    wr(8'h20, 32'h000000FF);
    rd(8'h20);
    wr(8'h28, 32'h000000FF);
    for (int m = 0; m < 2; m++) begin
      wr(8'h04, 32'(m));
      for (int i = 2; i < 9; i++) begin
        ev(9'h001 << i);
        rd(8'h20);
      end
    end
    rd(8'h24);
    wr(8'h24, 32'h000000FF);
    wr(8'h04, 32'h0);
    ev(9'h010);
    ev(9'h010);
    rd(8'h20);
    ev(9'h010);
    ev(9'h002);
    ev(9'h010);
    rd(8'h20);
    ev(9'h008);
    ev(9'h008);
    rd(8'h20);
    ev(9'h012);
    ev(9'h010);
    rd(8'h20);
    step(1'b0, 1'b1, 8'h20, 32'h0, 9'h020);
    rd(8'h20);
    rd(8'h20);
    wr(8'h28, 32'h00000010);
    wr(8'h24, 32'h000000FF);
    repeat (400) begin
      r = 1'($urandom % 2);
      w = !r && 1'($urandom % 2);
      e = ($urandom % 3 == 0) ? 9'($urandom) : '0;
      step(w, r, regs[$urandom % 5], $urandom, e);
    end
    ev(9'h000);
    ev(9'h000);
    wrap_up();
  end
endmodule : timer_channel_status_flags_tb
